// >>> src/cuer_dev.sv
// upset reporter: column and frame checks, error record, update copies and shift paths
//
// Notes on behaviour
// [RULE1] record holds 16-bit frame number
// [RULE2] 2-bit column double-word of four
// [RULE3] both bit-position fields are 5 bits
// [RULE4] separate column and frame type fields
// [RULE5] 32-bit syndrome, nonzero raises flag
// [RULE6] 10-bit frame double-word field
// [RULE7] update failure sets flag until reset
// [RULE8] frame type code encoding
// [RULE9] column type code encoding
// [RULE10] record readable by user or jtag path
// [RULE11] parallel column checks hand frame onward
// [RULE12] localized upset gives two flag pulses
// [RULE13] flag high until record ready
// [RULE14] record valid at second pulse fall
// [RULE15] unlocatable uncorrectable gives one pulse
// [RULE16] reader never infers correctability from count
// [RULE17] scrubbing corrects correctable upsets
// [RULE18] system soft resets after each upset
// [RULE19] host reconfigures if soft reset fails
// [RULE20] record is 78 bits
// [RULE21] record rewritten on every detection; code takes a detection only while idle
// [RULE22] copies load one cycle after valid
// [RULE23] reader holds copy before transfer
// [RULE24] fields packed in order, reserved zero
`timescale 1ns/1ps
`default_nettype none
module cuer_dev (
    // clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          resetn_in,
    // reader link
    cuer_if.dev                                link,
    // column checkers
    input  wire logic [cuer_pkg::NUM_COLS-1:0] col_detect_in,
    input  wire logic [cuer_pkg::FRAME_W-1:0]  col_frame_in,
    input  wire logic [cuer_pkg::CDW_W-1:0]    col_dw_in,
    input  wire logic [cuer_pkg::BIT_W-1:0]    col_bit_in,
    input  wire logic [cuer_pkg::TYPE_W-1:0]   col_type_in,
    input  wire logic                          recompute_in,
    // frame checker
    output logic                               frm_req_out,
    output logic [cuer_pkg::FRAME_W-1:0]       frm_addr_out,
    input  wire logic                          frm_done_in,
    input  wire logic [cuer_pkg::SYN_W-1:0]    frm_syn_in,
    input  wire logic [cuer_pkg::FDW_W-1:0]    frm_dw_in,
    input  wire logic [cuer_pkg::BIT_W-1:0]    frm_bit_in,
    input  wire logic [cuer_pkg::TYPE_W-1:0]   frm_type_in,
    // scrubbing
    input  wire logic                          scrub_en_in,
    output logic                               scrub_req_out,
    output logic [cuer_pkg::FRAME_W-1:0]       scrub_frame_out,
    output logic [cuer_pkg::FDW_W-1:0]         scrub_dw_out,
    output logic [cuer_pkg::BIT_W-1:0]         scrub_bit_out,
    // status
    output logic                               err_flag_out,
    output logic                               rec_valid_out
);
    typedef enum logic [1:0] {S_IDLE, S_COL, S_FWAIT, S_FRM} cuer_state_t;

    cuer_state_t                    state_q;
    logic [cuer_pkg::CNT_W-1:0]     cnt_q;
    logic [cuer_pkg::REC_W-1:0]     rec_q;
    logic                           flag_q;
    logic                           updf_q;
    logic                           valid_q;
    logic                           valid_d1_q;
    logic                           detect;
    logic                           pulse_end;
    logic                           frm_hit;
    logic                           frm_fixable;

    // all column checkers run side by side; any of them starts the sequence
    assign detect    = |col_detect_in; // RULE11
    assign pulse_end = (cnt_q == cuer_pkg::CNT_W'(cuer_pkg::FLAG_PULSE_CYC - 1));
    assign frm_hit   = (frm_syn_in != '0); // RULE5
    // single-bit and double-adjacent frame errors are the correctable ones
    assign frm_fixable = (frm_type_in == cuer_pkg::TYPE_SINGLE) ||
                         (frm_type_in[2:1] == cuer_pkg::TYPE_DADJ_HI); // RULE8

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q     <= S_IDLE;
            cnt_q       <= '0;
            flag_q      <= 1'b0;
            valid_q     <= 1'b0;
            frm_req_out <= 1'b0;
        end else begin
            valid_q     <= 1'b0;
            frm_req_out <= 1'b0;
            cnt_q       <= cnt_q + 1'b1;
            unique case (state_q)
                S_IDLE: begin
                    if (detect) begin
                        state_q <= S_COL;
                        cnt_q   <= '0;
                        flag_q  <= 1'b1; // RULE13
                    end
                end
                S_COL: begin
                    if (pulse_end) begin
                        flag_q <= 1'b0;
                        if (rec_q[cuer_pkg::CTYPE_LSB +: cuer_pkg::TYPE_W] == cuer_pkg::TYPE_UNCORR) begin
                            // location cannot be found, so the first pulse is the only one
                            state_q <= S_IDLE; // RULE15
                            valid_q <= 1'b1;
                        end else begin
                            state_q     <= S_FWAIT;
                            frm_req_out <= 1'b1; // RULE11
                        end
                    end
                end
                S_FWAIT: begin
                    if (frm_done_in) begin
                        if (frm_hit) begin
                            state_q <= S_FRM; // RULE12
                            cnt_q   <= '0;
                            flag_q  <= 1'b1;
                        end else begin
                            state_q <= S_IDLE;
                            valid_q <= 1'b1;
                        end
                    end
                end
                S_FRM: begin
                    if (pulse_end) begin
                        state_q <= S_IDLE;
                        flag_q  <= 1'b0;
                        valid_q <= 1'b1; // RULE14
                    end
                end
            endcase
        end
    end

    // only a full reset, standing for reconfiguration, clears an update failure
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            updf_q <= 1'b0;
        end else if (detect && recompute_in) begin
            updf_q <= 1'b1; // RULE7
        end
    end

    // detections while a sequence runs are not taken, so a record is never mixed
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rec_q        <= cuer_pkg::REC_RESET;
            frm_addr_out <= '0;
        end else begin
            if (state_q == S_IDLE && detect) begin
                rec_q <= cuer_pkg::REC_RESET; // RULE21
                rec_q[cuer_pkg::FRAME_LSB +: cuer_pkg::FRAME_W] <= col_frame_in; // RULE1
                rec_q[cuer_pkg::CDW_LSB +: cuer_pkg::CDW_W]     <= col_dw_in; // RULE2
                rec_q[cuer_pkg::CBIT_LSB +: cuer_pkg::BIT_W]    <= col_bit_in; // RULE3
                rec_q[cuer_pkg::CTYPE_LSB +: cuer_pkg::TYPE_W]  <= col_type_in; // RULE4 RULE9
                rec_q[cuer_pkg::UPDF_BIT] <= updf_q | recompute_in; // RULE7
                frm_addr_out <= col_frame_in;
            end else if (state_q == S_FWAIT && frm_done_in) begin
                rec_q[cuer_pkg::SYN_LSB +: cuer_pkg::SYN_W]     <= frm_syn_in; // RULE5
                rec_q[cuer_pkg::FDW_LSB +: cuer_pkg::FDW_W]     <= frm_dw_in; // RULE6
                rec_q[cuer_pkg::FBIT_LSB +: cuer_pkg::BIT_W]    <= frm_bit_in; // RULE3
                rec_q[cuer_pkg::FTYPE_LSB +: cuer_pkg::TYPE_W]  <= frm_type_in; // RULE4 RULE8
            end
            rec_q[cuer_pkg::RSV_BIT] <= 1'b0; // RULE24
        end
    end

    // scrub request for a located, correctable frame error
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scrub_req_out   <= 1'b0;
            scrub_frame_out <= '0;
            scrub_dw_out    <= '0;
            scrub_bit_out   <= '0;
        end else begin
            scrub_req_out <= 1'b0;
            if (state_q == S_FWAIT && frm_done_in && frm_hit && frm_fixable && scrub_en_in) begin
                scrub_req_out   <= 1'b1; // RULE17
                scrub_frame_out <= rec_q[cuer_pkg::FRAME_LSB +: cuer_pkg::FRAME_W];
                scrub_dw_out    <= frm_dw_in;
                scrub_bit_out   <= frm_bit_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            valid_d1_q <= 1'b0;
        end else begin
            valid_d1_q <= valid_q;
        end
    end

    assign err_flag_out  = flag_q | updf_q; // RULE7
    assign link.err_flag = flag_q | updf_q;
    assign rec_valid_out = valid_q;

    // one update copy and shift register per readout path
    for (genvar c = 0; c < cuer_pkg::NUM_CH; c++) begin : g_ch
        logic [cuer_pkg::REC_W-1:0] copy_q;
        logic [cuer_pkg::REC_W-1:0] sreg_q;
        logic                       path_en;

        // the jtag path answers only while the unload instruction is selected
        assign path_en = (c == cuer_pkg::CH_USER) ||
                         (link.jtag_ir == cuer_pkg::UNLOAD_INSTR); // RULE10

        // a held copy misses later updates; that keeps a read consistent
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                copy_q <= cuer_pkg::REC_RESET;
            end else if (valid_d1_q && !link.hold[c]) begin
                copy_q <= rec_q; // RULE22 RULE23
            end
        end

        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                sreg_q <= cuer_pkg::REC_RESET;
            end else if (path_en && link.load[c]) begin
                sreg_q <= copy_q; // RULE10
            end else if (path_en && link.shift[c]) begin
                sreg_q <= {sreg_q[cuer_pkg::REC_W-2:0], 1'b0};
            end
        end

        assign link.sdata[c] = sreg_q[cuer_pkg::REC_W-1]; // RULE20
    end
endmodule
`default_nettype wire

// >>> shared/cuer_pkg.sv
// constants shared by the upset reporter device end and its reader end
package cuer_pkg;
    // error record layout, packed from frame number down to the update flag
    localparam int REC_W      = 78;
    localparam int FRAME_W    = 16;
    localparam int CDW_W      = 2;
    localparam int BIT_W      = 5;
    localparam int TYPE_W     = 3;
    localparam int SYN_W      = 32;
    localparam int FDW_W      = 10;
    localparam int FRAME_LSB  = 62;
    localparam int CDW_LSB    = 60;
    localparam int CBIT_LSB   = 55;
    localparam int CTYPE_LSB  = 52;
    localparam int SYN_LSB    = 20;
    localparam int FDW_LSB    = 10;
    localparam int FBIT_LSB   = 5;
    localparam int FTYPE_LSB  = 2;
    localparam int RSV_BIT    = 1;
    localparam int UPDF_BIT   = 0;
    localparam logic [REC_W-1:0] REC_RESET = 78'h0;

    // error type codes
    localparam logic [TYPE_W-1:0] TYPE_NONE   = 3'h0;
    localparam logic [TYPE_W-1:0] TYPE_SINGLE = 3'h1;
    localparam logic [TYPE_W-1:0] TYPE_UNCORR = 3'h7;
    localparam logic [1:0]        TYPE_DADJ_HI = 2'h1;

    // parallel column checkers
    localparam int NUM_COLS = 8;

    // readout channels
    localparam int NUM_CH  = 2;
    localparam int CH_USER = 0;
    localparam int CH_JTAG = 1;
    localparam int IR_W    = 10;
    // arbitrary instruction code
    localparam logic [IR_W-1:0] UNLOAD_INSTR = 10'h017;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int FLAG_PULSE_NS = 100;
    localparam int FLAG_PULSE_CYC = (FLAG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;

    // reader register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_REC0   = 8'h08;
    localparam logic [ADDR_W-1:0] REG_REC1   = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_REC2   = 8'h10;
    localparam int CTRL_GO      = 0;
    localparam int CTRL_PATH    = 1;
    localparam int CTRL_CLRDONE = 2;
    localparam int CTRL_SOFTRST = 3;
    localparam int CTRL_RECONF  = 4;
    localparam int ST_BUSY      = 0;
    localparam int ST_DONE      = 1;
    localparam int ST_FLAG      = 2;
    localparam int ST_RECONF    = 3;
    localparam int ST_PCNT_LSB  = 4;
    localparam int PCNT_W       = 4;
    localparam int BCNT_W       = 7;
endpackage

// >>> shared/cuer_if.sv
// link between the upset reporter and the record reader
`timescale 1ns/1ps
`default_nettype none
interface cuer_if;
    logic                          err_flag;
    logic [cuer_pkg::NUM_CH-1:0]   hold;
    logic [cuer_pkg::NUM_CH-1:0]   load;
    logic [cuer_pkg::NUM_CH-1:0]   shift;
    logic [cuer_pkg::NUM_CH-1:0]   sdata;
    logic [cuer_pkg::IR_W-1:0]     jtag_ir;

    modport dev (
        input  hold, load, shift, jtag_ir,
        output err_flag, sdata
    );
    modport rdr (
        output hold, load, shift, jtag_ir,
        input  err_flag, sdata
    );
endinterface
`default_nettype wire

// >>> src/cuer_rdr.sv
// record reader: unloads the error record over the user or jtag path
`timescale 1ns/1ps
`default_nettype none
module cuer_rdr (
    // clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        resetn_in,
    // device link
    cuer_if.rdr                              link,
    // register port
    input  wire logic [cuer_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [31:0]                 wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic [31:0]                      rdata_out,
    // system recovery
    output logic                             soft_reset_out,
    output logic                             reconfig_out
);
    typedef enum logic [1:0] {R_IDLE, R_HOLD, R_LOAD, R_SHIFT} cuer_rstate_t;

    cuer_rstate_t                   state_q;
    logic [cuer_pkg::BCNT_W-1:0]    bcnt_q;
    logic [cuer_pkg::REC_W-1:0]     buf_q;
    logic [cuer_pkg::PCNT_W-1:0]    pcnt_q;
    logic                           path_q;
    logic                           done_q;
    logic                           flag_d_q;
    logic                           go;
    logic                           ctrl_wr;
    logic                           finish;
    logic                           busy;
    logic [cuer_pkg::NUM_CH-1:0]    sel;

    assign ctrl_wr = wr_in && (addr_in == cuer_pkg::REG_CTRL);
    // an unload may start only while the flag is low
    assign go      = ctrl_wr && wdata_in[cuer_pkg::CTRL_GO] && !link.err_flag && state_q == R_IDLE; // RULE13
    assign busy    = (state_q != R_IDLE);
    assign finish  = (state_q == R_SHIFT) && (bcnt_q == cuer_pkg::BCNT_W'(cuer_pkg::REC_W - 1));
    assign sel     = path_q ? cuer_pkg::NUM_CH'(1 << cuer_pkg::CH_JTAG) : cuer_pkg::NUM_CH'(1 << cuer_pkg::CH_USER);

    // hold spans the whole read so the copy cannot change underneath it
    assign link.hold    = busy ? sel : '0; // RULE23
    assign link.load    = (state_q == R_LOAD) ? sel : '0;
    assign link.shift   = (state_q == R_SHIFT) ? sel : '0;
    assign link.jtag_ir = (busy && path_q) ? cuer_pkg::UNLOAD_INSTR : '0; // RULE10

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= R_IDLE;
            bcnt_q  <= '0;
            buf_q   <= cuer_pkg::REC_RESET;
        end else begin
            unique case (state_q)
                R_IDLE: begin
                    if (go) begin
                        state_q <= R_HOLD;
                    end
                end
                R_HOLD: begin
                    state_q <= R_LOAD;
                end
                R_LOAD: begin
                    state_q <= R_SHIFT;
                    bcnt_q  <= '0;
                end
                R_SHIFT: begin
                    buf_q  <= {buf_q[cuer_pkg::REC_W-2:0], link.sdata[path_q]};
                    bcnt_q <= bcnt_q + 1'b1;
                    if (finish) begin
                        state_q <= R_IDLE;
                    end
                end
            endcase
        end
    end

    // control register, done flag (set wins over clear), flag fall counter
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            path_q         <= 1'b0;
            done_q         <= 1'b0;
            reconfig_out   <= 1'b0;
            soft_reset_out <= 1'b0;
            flag_d_q       <= 1'b0;
            pcnt_q         <= '0;
        end else begin
            flag_d_q       <= link.err_flag;
            soft_reset_out <= ctrl_wr && wdata_in[cuer_pkg::CTRL_SOFTRST]; // RULE18
            if (ctrl_wr) begin
                reconfig_out <= wdata_in[cuer_pkg::CTRL_RECONF]; // RULE19
                if (!busy) begin
                    path_q <= wdata_in[cuer_pkg::CTRL_PATH];
                end
            end
            if (finish) begin
                done_q <= 1'b1;
            end else if (ctrl_wr && wdata_in[cuer_pkg::CTRL_CLRDONE]) begin
                done_q <= 1'b0;
            end
            // pulse count is only reported; type fields decide correctability
            if (flag_d_q && !link.err_flag && pcnt_q != '1) begin
                pcnt_q <= pcnt_q + 1'b1; // RULE16
            end else if (go) begin
                pcnt_q <= '0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= '0;
            if (rd_in) begin
                unique case (addr_in)
                    cuer_pkg::REG_CTRL: begin
                        rdata_out[cuer_pkg::CTRL_PATH]   <= path_q;
                        rdata_out[cuer_pkg::CTRL_RECONF] <= reconfig_out;
                    end
                    cuer_pkg::REG_STATUS: begin
                        rdata_out[cuer_pkg::ST_BUSY]   <= busy;
                        rdata_out[cuer_pkg::ST_DONE]   <= done_q;
                        rdata_out[cuer_pkg::ST_FLAG]   <= link.err_flag;
                        rdata_out[cuer_pkg::ST_RECONF] <= reconfig_out;
                        rdata_out[cuer_pkg::ST_PCNT_LSB +: cuer_pkg::PCNT_W] <= pcnt_q;
                    end
                    cuer_pkg::REG_REC0: rdata_out <= buf_q[31:0];
                    cuer_pkg::REG_REC1: rdata_out <= buf_q[63:32];
                    cuer_pkg::REG_REC2: rdata_out <= {18'h0, buf_q[cuer_pkg::REC_W-1:64]};
                    default: rdata_out <= '0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/cuer_assertions.sv
// concurrent checks on the reporter to reader link
`timescale 1ns/1ps
`default_nettype none
module cuer_assertions (
    input wire logic                        clk_in,
    input wire logic                        resetn_in,
    input wire logic                        err_flag,
    input wire logic [cuer_pkg::NUM_CH-1:0] hold,
    input wire logic [cuer_pkg::NUM_CH-1:0] load,
    input wire logic [cuer_pkg::NUM_CH-1:0] shift,
    input wire logic [cuer_pkg::NUM_CH-1:0] sdata,
    input wire logic [cuer_pkg::IR_W-1:0]   jtag_ir
);
    logic [7:0] fcnt_q;
    logic [7:0] scnt_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // run lengths are counted so pulse and shift widths are checked exactly
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) fcnt_q <= 8'h00;
        else if (!err_flag) fcnt_q <= 8'h00;
        else if (fcnt_q != 8'hFF) fcnt_q <= fcnt_q + 8'h01;
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) scnt_q <= 8'h00;
        else if (shift == 2'h0) scnt_q <= 8'h00;
        else if (scnt_q != 8'hFF) scnt_q <= scnt_q + 8'h01;
    end
    sequence s_unload;
        (load != 2'h0) ##1 (shift != 2'h0);
    endsequence
    a_flag_width: assert property ($rose(err_flag) |-> err_flag[*5])
        else $error("flag pulse too short");
    a_flag_fall: assert property ($fell(err_flag) |-> fcnt_q == 8'h05)
        else $error("flag pulse length wrong");
    a_go_idle: assert property ($rose(hold != 2'h0) |-> !$past(err_flag))
        else $error("unload began while flag high");
    a_hold_seq: assert property ($rose(hold != 2'h0) |=> s_unload)
        else $error("hold not followed by load then shift");
    a_shift_len: assert property ($fell(shift != 2'h0) |-> scnt_q == 8'h4E)
        else $error("shift run not 78 cycles");
    a_hold_release: assert property ($fell(shift != 2'h0) |-> hold == 2'h0)
        else $error("hold kept after shift");
    a_shift_held: assert property ((shift != 2'h0) |-> (hold & shift) == shift)
        else $error("shift without hold");
    a_jtag_instr: assert property (load[1] |-> jtag_ir == cuer_pkg::UNLOAD_INSTR)
        else $error("jtag load without unload instruction");
    a_one_path: assert property (hold != 2'h3)
        else $error("both paths held");
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the upset reporter and record reader pair
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_in, resetn_in, recomp, fdone, scrub, freq, sreq, flag, rval, wr, rd, srst, reconf;
    logic [7:0]  det, addr;
    logic [15:0] cfr, faddr, sfr;
    logic [1:0]  cdw;
    logic [4:0]  cbit, fbit, sbit;
    logic [2:0]  ctyp, ftyp;
    logic [31:0] fsyn, wdata, rdata;
    logic [9:0]  fdw, sdw;
    int          n_fail;
    int          total_checks;
    cuer_if link ();
    cuer_dev u_cuer_dev (.clk_in(clk_in), .resetn_in(resetn_in), .link(link), .col_detect_in(det),
        .col_frame_in(cfr), .col_dw_in(cdw), .col_bit_in(cbit), .col_type_in(ctyp), .recompute_in(recomp),
        .frm_req_out(freq), .frm_addr_out(faddr), .frm_done_in(fdone), .frm_syn_in(fsyn), .frm_dw_in(fdw),
        .frm_bit_in(fbit), .frm_type_in(ftyp), .scrub_en_in(scrub), .scrub_req_out(sreq),
        .scrub_frame_out(sfr), .scrub_dw_out(sdw), .scrub_bit_out(sbit), .err_flag_out(flag),
        .rec_valid_out(rval));
    cuer_rdr u_cuer_rdr (.clk_in(clk_in), .resetn_in(resetn_in), .link(link), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .soft_reset_out(srst),
        .reconfig_out(reconf));
    cuer_assertions u_cuer_assertions (.clk_in(clk_in), .resetn_in(resetn_in), .err_flag(link.err_flag),
        .hold(link.hold), .load(link.load), .shift(link.shift), .sdata(link.sdata), .jtag_ir(link.jtag_ir));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    task automatic test_done();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [77:0] seen, input logic [77:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tmo();
        n_fail++;
        $display("[ERR] %0t wait ran out", $time);
        test_done();
    endtask
    task automatic wt(ref logic s);
        for (int i = 0; i < 300; i++) begin
            @(posedge clk_in);
            #1;
            if (s === 1'b1) return;
        end
        tmo();
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // plays the frame checker; a detect under recompute is left hanging until reset
    task automatic upset(input logic [15:0] fr, input logic [2:0] ct, input logic [2:0] ft,
                         input logic [31:0] sy, input logic up, output logic [77:0] e);
        @(posedge clk_in);
        det <= 8'h01 << fr[2:0];
        cfr <= fr;
        cdw <= fr[1:0];
        cbit <= fr[6:2];
        ctyp <= ct;
        recomp <= up;
        @(posedge clk_in);
        det <= 8'h00;
        e = {fr, fr[1:0], fr[6:2], ct, 50'h0, 1'b0, up};
        if (ct != 3'h7 && !up) begin
            wt(freq);
            chk(78'(faddr), 78'(fr));
            repeat (3) @(posedge clk_in);
            fdone <= 1'b1;
            fsyn <= sy;
            fdw <= fr[9:0];
            fbit <= fr[15:11];
            ftyp <= ft;
            @(posedge clk_in);
            fdone <= 1'b0;
            #1;
            chk(78'(sreq), 78'(sy != 0 && (ft == 3'h1 || ft[2:1] == 2'h1)));
            if (sreq === 1'b1) chk(78'({sfr, sdw, sbit}), 78'({fr, fr[9:0], fr[15:11]}));
            e[51:2] = {sy, fr[9:0], fr[15:11], ft};
        end
        // a zero syndrome closes the record in the cycle of the frame result
        if (!up && rval !== 1'b1) wt(rval);
    endtask
    task automatic unload(input logic p, output logic [77:0] r);
        logic [31:0] d;
        logic [31:0] d1;
        logic [31:0] d2;
        wr_reg(cuer_pkg::REG_CTRL, {30'h0, p, 1'b0});
        wr_reg(cuer_pkg::REG_CTRL, {30'h0, p, 1'b1});
        d = 32'h0;
        for (int i = 0; i < 100 && d[cuer_pkg::ST_DONE] !== 1'b1; i++) rd_reg(cuer_pkg::REG_STATUS, d);
        if (d[cuer_pkg::ST_DONE] !== 1'b1) tmo();
        rd_reg(cuer_pkg::REG_REC0, d);
        rd_reg(cuer_pkg::REG_REC1, d1);
        rd_reg(cuer_pkg::REG_REC2, d2);
        r = {d2[13:0], d1, d};
        wr_reg(cuer_pkg::REG_CTRL, 32'h4);
    endtask
    task automatic t_event(input logic [15:0] fr, input logic [2:0] ct, input logic [2:0] ft,
                           input logic [31:0] sy, input logic p, input logic [3:0] np);
        logic [77:0] e;
        logic [77:0] r;
        logic [31:0] s;
        upset(fr, ct, ft, sy, 1'b0, e);
        rd_reg(cuer_pkg::REG_STATUS, s);
        chk(78'(s[7:4]), 78'(np));
        chk(78'(s[2]), 78'(0));
        unload(p, r);
        chk(r, e);
    endtask
    task automatic t_types();
        logic [2:0] ct [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
        logic [2:0] ft [5] = '{3'h2, 3'h3, 3'h7, 3'h1, 3'h7};
        for (int i = 0; i < 5; i++) t_event(16'(16'h3C10 + i * 7), ct[i], ft[i], 32'hC0DE_0000 | i, i[0], 4'h2);
        $display("type code test done");
    endtask
    task automatic t_updf();
        logic [77:0] e;
        logic [31:0] s;
        upset(16'h0F00, 3'h1, 3'h1, 32'h0, 1'b1, e);
        repeat (20) @(posedge clk_in);
        rd_reg(cuer_pkg::REG_STATUS, s);
        chk(78'(s[2:0]), 78'(3'h4));
        wr_reg(cuer_pkg::REG_CTRL, 32'h1);
        rd_reg(cuer_pkg::REG_STATUS, s);
        chk(78'(s[1:0]), 78'(0));
        @(posedge clk_in);
        resetn_in <= 1'b0;
        recomp <= 1'b0;
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1;
        chk(78'(flag), 78'(0));
        $display("update failure test done");
    endtask
    task automatic t_sys();
        logic [31:0] s;
        wr_reg(cuer_pkg::REG_CTRL, 32'h8);
        #1;
        chk(78'(srst), 78'(1));
        wr_reg(cuer_pkg::REG_CTRL, 32'h10);
        rd_reg(cuer_pkg::REG_STATUS, s);
        chk(78'({reconf, s[3]}), 78'(2'h3));
        rd_reg(cuer_pkg::REG_CTRL, s);
        chk(78'(s[4:0]), 78'(5'h10));
        rd_reg(8'hFC, s);
        chk(78'(s), 78'(0));
        $display("recovery test done");
    endtask
    initial begin
        n_fail = 0;
        total_checks = 0;
        resetn_in = 1'b0;
        {det, cfr, cdw, cbit, ctyp, recomp, fdone, fsyn, fdw, fbit, ftyp, scrub, addr, wdata, wr, rd} = '0;
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        scrub <= 1'b1;
        t_event(16'hA5C3, 3'h1, 3'h1, 32'h1234_5678, 1'b0, 4'h2);
        t_event(16'h7777, 3'h7, 3'h0, 32'h0, 1'b1, 4'h1);
        t_event(16'h0042, 3'h1, 3'h1, 32'h0, 1'b0, 4'h1);
        $display("single event tests done");
        t_types();
        t_sys();
        t_updf();
        test_done();
    end
endmodule
`default_nettype wire
